// ### sdip_pkg.sv
// Purpose: Constants for the serial DAC input port
// Assumes: 8-bit data word, MSB first
// Notes: Used by the port, which passes the FIFO its width and depth
package sdip_pkg;
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [7:0] DAC_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : sdip_pkg

// ### sdip_stream_if.sv
// Purpose: Valid/ready word stream between link and core domains
// Assumes: Single clock per side
// Notes: Carries the FIFO ports
`timescale 1ns/10ps
`default_nettype none
interface sdip_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sdip_stream_if
`default_nettype wire

// ### sdip_fifo.sv
// Purpose: Dual-clock FIFO with gray-coded pointers
// Assumes: Depth is a power of two
// Notes: Write side on link clock, read side on core clock
`timescale 1ns/10ps
`default_nettype none
module sdip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic wclk_i,
  input wire logic wrst_i,
  sdip_stream_if.snk wr,
  input wire logic rclk_i,
  input wire logic rrst_i,
  sdip_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("sdip_fifo: bad parameters");
    end
  end
  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr, next_wptr, rptr, next_rptr;
  logic [AW:0] wgray, rgray;
  logic [AW:0] rgray_w1, rgray_w2, wgray_r1, wgray_r2;
  logic full, empty;
  assign full = (wgray == {~rgray_w2[AW:AW-1], rgray_w2[AW-2:0]});
  assign empty = (rgray == wgray_r2);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data = mem[rptr[AW-1:0]];
  always_comb begin
    next_wptr = wptr;
    if (wr.valid && !full) begin
      next_wptr = wptr + 1'b1;
    end
  end
  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      wptr <= '0;
      wgray <= '0;
      rgray_w1 <= '0;
      rgray_w2 <= '0;
    end else begin
      wptr <= next_wptr;
      wgray <= bin2gray(next_wptr);
      rgray_w1 <= rgray;
      rgray_w2 <= rgray_w1;
    end
  end
  always_ff @(posedge wclk_i) begin
    if (wr.valid && !full) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end
  always_comb begin
    next_rptr = rptr;
    if (rd.ready && !empty) begin
      next_rptr = rptr + 1'b1;
    end
  end
  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rptr <= '0;
      rgray <= '0;
      wgray_r1 <= '0;
      wgray_r2 <= '0;
    end else begin
      rptr <= next_rptr;
      rgray <= bin2gray(next_rptr);
      wgray_r1 <= wgray;
      wgray_r2 <= wgray_r1;
    end
  end
endmodule : sdip_fifo
`default_nettype wire

// ### sdip_port.sv
// Purpose: Serial input port of an 8-bit DAC, link side and DAC register
// Assumes: Link clock and frame are driven by the host
// Notes: Words cross to the core clock through a dual-clock FIFO
`timescale 1ns/10ps
`default_nettype none
module sdip_port #(
  parameter int WORD_BITS = sdip_pkg::WORD_BITS,
  parameter int FIFO_DEPTH = sdip_pkg::FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic host_shift_clock_i,
  input wire logic host_transmit_frame_n_i,
  input wire logic serial_data_i,
  input wire logic load_dac_strobe_n_i,
  input wire logic load_mode_i,
  output logic [WORD_BITS-1:0] dac_code_o,
  output logic dac_update_o,
  output logic word_pending_o
);
  initial begin
    if (WORD_BITS != 8) begin
      $error("sdip_port: only an 8-bit word is served");
    end
  end
  // Link reset: core reset brought into the link domain
  logic lrst_1, lrst;
  always_ff @(negedge host_shift_clock_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_1 <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_1 <= 1'b0;
      lrst <= lrst_1;
    end
  end
  // Frame rising edge ends a frame; its low level opens the port
  logic [WORD_BITS-1:0] shift, next_shift;
  logic [3:0] count, next_count;
  always_comb begin
    next_shift = shift;
    next_count = count;
    if (!host_transmit_frame_n_i) begin
      if (count < 4'(WORD_BITS)) begin
        next_shift = {shift[WORD_BITS-2:0], serial_data_i};
        next_count = count + 4'h1;
      end
    end
  end
  logic frame_seen;
  always_ff @(negedge host_shift_clock_i or posedge host_transmit_frame_n_i) begin
    if (host_transmit_frame_n_i) begin
      frame_seen <= 1'b0;
    end else begin
      frame_seen <= 1'b1;
    end
  end
  always_ff @(negedge host_shift_clock_i or posedge lrst) begin
    if (lrst) begin
      shift <= sdip_pkg::SHIFT_RESET;
      count <= sdip_pkg::COUNT_RESET;
    end else if (!frame_seen) begin
      shift <= {shift[WORD_BITS-2:0], serial_data_i};
      count <= host_transmit_frame_n_i ? sdip_pkg::COUNT_RESET : 4'h1;
    end else begin
      shift <= next_shift;
      count <= next_count;
    end
  end
  // Word is queued for the FIFO on the frame rising edge only if complete
  sdip_stream_if #(.W(WORD_BITS)) wr_s ();
  sdip_stream_if #(.W(WORD_BITS)) rd_s ();
  logic push_req, next_push_req, push_done, next_push_done;
  logic [WORD_BITS-1:0] push_data, next_push_data;
  always_comb begin
    next_push_req = push_req;
    next_push_data = push_data;
    if (count == 4'(WORD_BITS) && push_req == push_done) begin
      next_push_req = ~push_req;
      next_push_data = shift;
    end
  end
  always_ff @(posedge host_transmit_frame_n_i or posedge lrst) begin
    if (lrst) begin
      push_req <= 1'b0;
      push_data <= sdip_pkg::SHIFT_RESET;
    end else begin
      push_req <= next_push_req;
      push_data <= next_push_data;
    end
  end
  // Toggle crosses on two falling link edges
  logic push_seen;
  logic push_1, push_2;
  always_ff @(negedge host_shift_clock_i or posedge lrst) begin
    if (lrst) begin
      push_1 <= 1'b0;
      push_2 <= 1'b0;
    end else begin
      push_1 <= push_req;
      push_2 <= push_1;
    end
  end
  // Acknowledge on the FIFO's own write edge, so a full FIFO never takes a word twice
  always_comb begin
    next_push_done = push_done;
    if (push_seen && wr_s.ready) begin
      next_push_done = push_2;
    end
  end
  always_ff @(posedge host_shift_clock_i or posedge lrst) begin
    if (lrst) begin
      push_done <= 1'b0;
    end else begin
      push_done <= next_push_done;
    end
  end
  assign push_seen = (push_2 != push_done);
  sequence push_taken_s;
    push_seen && wr_s.ready;
  endsequence
  push_once_a: assert property (@(posedge host_shift_clock_i) disable iff (lrst)
    push_taken_s |=> !push_seen) else $error("word written twice");
  full_push_a: assert property (@(posedge host_transmit_frame_n_i) disable iff (lrst)
    (count == 4'(WORD_BITS) && push_req == push_done) |=> !$stable(push_req))
    else $error("complete word not pushed");
  assign wr_s.valid = push_seen;
  assign wr_s.data = push_data;
  sdip_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk_i(host_shift_clock_i),
    .wrst_i(lrst),
    .wr(wr_s.snk),
    .rclk_i(clock_i),
    .rrst_i(rst_i),
    .rd(rd_s.src)
  );
  // Core side: strobe and mode pins synchronised
  logic [1:0] load_dac_strobe_n_sync, mode_sync;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      load_dac_strobe_n_sync <= 2'b11;
      mode_sync <= 2'b00;
    end else begin
      load_dac_strobe_n_sync <= {load_dac_strobe_n_sync[0], load_dac_strobe_n_i};
      mode_sync <= {mode_sync[0], load_mode_i};
    end
  end
  typedef enum logic [2:0] {
    SDIP_IDLE = 3'b001,
    SDIP_HOLD = 3'b010,
    SDIP_LOAD = 3'b100
  } sdip_state_e;
  sdip_state_e state, next_state;
  logic [WORD_BITS-1:0] held, next_held, dac, next_dac;
  logic upd, next_upd;
  always_comb begin
    next_state = state;
    next_held = held;
    next_dac = dac;
    next_upd = 1'b0;
    rd_s.ready = 1'b0;
    unique case (state)
      SDIP_IDLE: begin
        if (rd_s.valid) begin
          rd_s.ready = 1'b1;
          next_held = rd_s.data;
          next_state = mode_sync[1] ? SDIP_HOLD : SDIP_LOAD;
        end
      end
      SDIP_HOLD: begin
        if (!load_dac_strobe_n_sync[1]) begin
          next_state = SDIP_LOAD;
        end
      end
      SDIP_LOAD: begin
        next_dac = held;
        next_upd = 1'b1;
        next_state = SDIP_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= SDIP_IDLE;
      held <= sdip_pkg::DAC_RESET;
      dac <= sdip_pkg::DAC_RESET;
      upd <= 1'b0;
    end else begin
      state <= next_state;
      held <= next_held;
      dac <= next_dac;
      upd <= next_upd;
    end
  end
  logic pend;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pend <= 1'b0;
    end else begin
      pend <= (next_state == SDIP_HOLD);
    end
  end
  assign dac_code_o = dac;
  assign dac_update_o = upd;
  assign word_pending_o = pend;
  sequence load_step_s;
    state == SDIP_LOAD;
  endsequence
  sequence code_moved_s;
    ##1 (dac == $past(held)) && upd;
  endsequence
  dac_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
    load_step_s |-> code_moved_s) else $error("DAC code not loaded");
  update_once_a: assert property (@(posedge clock_i) disable iff (rst_i)
    upd |=> !upd) else $error("update pulse too long");
  direct_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SDIP_IDLE && rd_s.valid && !mode_sync[1]) |=> load_step_s)
    else $error("frame-end load missed");
  hold_entry_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SDIP_IDLE && rd_s.valid && mode_sync[1]) |=> (state == SDIP_HOLD && pend))
    else $error("word not held for strobe");
  hold_strobe_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SDIP_HOLD && !load_dac_strobe_n_sync[1]) |-> ##2 upd) else $error("strobe load missed");
  hold_wait_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SDIP_HOLD && load_dac_strobe_n_sync[1]) |=> !upd) else $error("load without strobe");
  pend_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
    pend == (state == SDIP_HOLD)) else $error("pending flag wrong");
  no_spurious_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state != SDIP_LOAD) |=> $stable(dac)) else $error("DAC changed without load");
  idle_quiet_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SDIP_IDLE) |=> !upd) else $error("update while idle");
  short_frame_a: assert property (@(posedge host_transmit_frame_n_i) disable iff (lrst)
    (count != 4'(WORD_BITS)) |=> $stable(push_req)) else $error("short word pushed");
  idle_port_a: assert property (@(negedge host_shift_clock_i) disable iff (lrst)
    host_transmit_frame_n_i |=> (count == sdip_pkg::COUNT_RESET)) else $error("idle shift");
  fresh_frame_a: assert property (@(negedge host_shift_clock_i) disable iff (lrst)
    (!host_transmit_frame_n_i && !frame_seen) |=> (count == 4'h1))
    else $error("frame start not fresh");
  count_cap_a: assert property (@(negedge host_shift_clock_i) disable iff (lrst)
    count <= 4'(WORD_BITS)) else $error("word overrun");
  msb_first_a: assert property (@(negedge host_shift_clock_i) disable iff (lrst)
    (!host_transmit_frame_n_i && frame_seen && count < 4'(WORD_BITS))
    |=> shift[0] == $past(serial_data_i)) else $error("bit order wrong");
endmodule : sdip_port
`default_nettype wire

// ### sdip_host_model.sv
// Purpose: Host serial master driving frames into the DAC port
// Assumes: Link clock of 6 ns, idle low, runs within frames and also between them
// Notes: Data line scrambled whenever the frame is high
`timescale 1ns/10ps
`default_nettype none
module sdip_host_model (
  output logic sck_o,
  output logic frame_n_o,
  output logic sdo_o
);
  initial begin
    sck_o = 1'b0;
    frame_n_o = 1'b1;
    sdo_o = 1'b0;
  end
  // One frame; nbits above 8 is a deliberate overlong frame
  task automatic send(input logic [7:0] word, input int nbits);
    int i;
    #1.3 frame_n_o = 1'b0;
    #3;
    for (i = 0; i < nbits; i++) begin
      sck_o = 1'b1;
      sdo_o = word[7 - (i % 8)];
      #3 sck_o = 1'b0;
      #3;
    end
    frame_n_o = 1'b1;
    sdo_o = ~sdo_o;
    idle(3);
  endtask : send
  // Clock edges with frame high carry random data
  task automatic idle(input int n);
    repeat (n) begin
      sck_o = 1'b1;
      sdo_o = 1'($urandom);
      #3 sck_o = 1'b0;
      #3;
    end
  endtask : idle
endmodule : sdip_host_model
`default_nettype wire

// ### test_serial_dac_input_port.sv
// Purpose: Self-checking bench for the serial DAC input port
// Assumes: Default word width and FIFO depth
// Notes: Expected words queued by the driver, checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module test_serial_dac_input_port;
  logic clock_i = 1'b0;
  logic rst_i = 1'b0;
  logic load_dac_strobe_n_i = 1'b1;
  logic load_mode_i = 1'b0;
  wire sck;
  wire frame_n;
  wire sdata;
  logic [7:0] dac_code;
  logic dac_update;
  logic word_pending;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int i;
  always #5 clock_i = ~clock_i;
  sdip_host_model u_sdip_host_model (.sck_o(sck), .frame_n_o(frame_n), .sdo_o(sdata));
  sdip_port u_sdip_port (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .host_shift_clock_i(sck),
    .host_transmit_frame_n_i(frame_n),
    .serial_data_i(sdata),
    .load_dac_strobe_n_i(load_dac_strobe_n_i),
    .load_mode_i(load_mode_i),
    .dac_code_o(dac_code),
    .dac_update_o(dac_update),
    .word_pending_o(word_pending)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic frame(input logic [7:0] word, input int nbits, input bit expect_it);
    if (expect_it) begin
      exp_q.push_back(word);
    end
    u_sdip_host_model.send(word, nbits);
  endtask : frame
  task automatic drain(input string name);
    int j;
    for (j = 0; j < 300 && exp_q.size() != 0; j++) begin
      @(posedge clock_i);
    end
    repeat (20) @(posedge clock_i);
    check(8'(exp_q.size()), 8'h00);
    $display("test %s done", name);
  endtask : drain
  // Monitor: every update pulse takes the oldest expected word
  always @(negedge clock_i) begin
    if (dac_update === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(8'h01, 8'h00);
      end else begin
        check(dac_code, exp_q.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32));
    #1 rst_i = 1'b1;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    u_sdip_host_model.idle(4);
    @(posedge clock_i) #1;
    check(dac_code, 8'h00);
    check({7'h00, word_pending}, 8'h00);
    $display("test reset done");
    // Back-to-back frames, extreme and random codes
    frame(8'h00, 8, 1'b1);
    frame(8'hFF, 8, 1'b1);
    for (i = 0; i < 8; i++) begin
      frame(8'($urandom), 8, 1'b1);
    end
    drain("stream");
    // Short frame dropped, overlong frame keeps its first eight bits
    frame(8'hA5, 5, 1'b0);
    frame(8'h3C, 11, 1'b1);
    u_sdip_host_model.idle(6);
    drain("short_long");
    // Strobe mode: word waits until the strobe goes low
    @(posedge clock_i) #1 load_mode_i = 1'b1;
    frame(8'h96, 8, 1'b1);
    repeat (30) @(posedge clock_i);
    #1 check({7'h00, word_pending}, 8'h01);
    check(8'(exp_q.size()), 8'h01);
    load_dac_strobe_n_i = 1'b0;
    drain("strobe");
    frame(8'h5A, 8, 1'b1);
    drain("strobe_held");
    // Fill the buffer while the strobe stalls, then release it
    @(posedge clock_i) #1 load_dac_strobe_n_i = 1'b1;
    for (i = 0; i < 18; i++) begin
      frame(8'($urandom), 8, 1'b1);
    end
    repeat (50) @(posedge clock_i);
    #1 check(8'(exp_q.size()), 8'h12);
    load_dac_strobe_n_i = 1'b0;
    repeat (20) @(posedge clock_i);
    u_sdip_host_model.idle(4);
    drain("fifo_fill");
    close_out();
  end
  initial begin
    #500000;
    n_mismatch++;
    close_out();
  end
endmodule : test_serial_dac_input_port
`default_nettype wire
